// file: verilog/cos_map.vh
// Purpose: constants for the overlay set checker
// Assumes: included by the design file, the host model and the bench
// Notes:   byte offsets on a 32-bit AHB-Lite register bus
`ifndef COS_MAP_VH
`define COS_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define COS_OFS_COMMAND      8'h00
`define COS_OFS_FEATURE      8'h04
`define COS_OFS_DEV_SELECT   8'h08
`define COS_OFS_DATA         8'h0C
`define COS_OFS_ERROR        8'h10
`define COS_OFS_MASK_LOW     8'h14
`define COS_OFS_MASK_HIGH    8'h18
`define COS_OFS_WORD_OFS     8'h1C
`define COS_OFS_STATUS       8'h20
`define COS_OFS_CONTROL      8'h24
`define COS_OFS_MODE_SEL     8'h28
`define COS_OFS_CUR_DMA      8'h2C
`define COS_OFS_CUR_FEAT     8'h30
`define COS_OFS_MAX_LOW      8'h34
`define COS_OFS_MAX_HIGH     8'h38
`define COS_OFS_SECTOR_COUNT 8'h3C

// ----------------------------------------
// Command codes and structure constants
// ----------------------------------------
`define COS_OPCODE           8'hB1
`define COS_SUBFN_SET        8'hC3
`define COS_SIGNATURE        8'hA5
`define COS_REVISION         16'h0001
`define COS_OFS_BAD_SUM      8'hFF
`define COS_OFS_BAD_REV      8'h00
`define COS_OFS_LBA          8'h03
`define COS_WORD_MDMA        8'h01
`define COS_WORD_UDMA        8'h02
`define COS_WORD_FEAT        8'h07
`define COS_LAST_WORD        8'hFF
`define COS_KEEP_WORDS       8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define COS_ERR_ABRT         2
`define COS_ST_BSY           7
`define COS_ST_DRDY          6
`define COS_ST_DF            5
`define COS_ST_DRQ           3
`define COS_ST_ERR           0
`define COS_DEV_BIT          4
`define COS_FEAT_HPA         7
`define COS_FEAT_STANDBY     4
`define COS_FEAT_SECURITY    3
`define COS_FEAT_SELFTEST    1
`define COS_FEAT_ERRLOG      2
`define COS_FEAT_SMART       0
`define COS_CTL_SUPPORTED    0
`define COS_CTL_FREEZE       1
`define COS_CTL_HPA          2
`define COS_CTL_SMART_ON     3
`define COS_CTL_SECURITY_ON  4
`define COS_CTL_JUMPER       5
`define COS_SEL_UDMA_LSB     8
`define COS_CTL_RESET        8'h01

`endif

// file: verilog/cos_overlay_set.v
// Purpose: device-side checker for the configuration overlay set command
// Assumes: one clock, AHB-Lite slave, zero wait states, word-only access
// Notes:
// Notes on behaviour
// [RL1] Opcode B1h with subfunction C3h starts command
// [RL2] Last word: signature A5h low, checksum high
// [RL3] Host sends two's complement byte checksum
// [RL4] Accept only when all 512 bytes sum zero
// [RL5] Revision word must equal 0001h
// [RL6] Word 1 multiword DMA, word 2 Ultra DMA
// [RL7] Words 3-6 max address, word 7 features
// [RL8] Abort on unsupported, modified, frozen, violation, HPA
// [RL9] Accepted clears reduce identify capability words
// [RL10] Bits beyond factory capability are ignored
// [RL11] New max address changes native max readback
// [RL12] Mask low byte on restriction abort, else 00h
// [RL13] Mask high byte on restriction abort, else 00h
// [RL14] Word offset of first unchangeable word reported
// [RL15] Illegal max address reports word offset 3
// [RL16] Checksum error reports offset FFh
// [RL17] Invalid revision reports offset 00h
// [RL18] Completion clears busy/request, sets ready, fault
// [RL19] Error status set when error register nonzero
// [RL20] Device select bit reflects selected device
// [RL21] Overlay arrives as 256 words before evaluation
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cos_map.vh"

module cos_overlay_set #(
  parameter [2:0] FACTORY_MDMA = 3'h7,
  parameter [5:0] FACTORY_UDMA = 6'h3F,
  parameter [8:0] FACTORY_FEAT = 9'h1FF,
  parameter [47:0] FACTORY_MAX_LBA = 48'h0000_1234_5678
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire device_fault,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  output reg [2:0] cur_mdma,
  output reg [5:0] cur_udma,
  output reg [8:0] cur_feat,
  output reg [47:0] native_max
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_XFER = 2'h1;
  localparam [1:0] ST_EVAL = 2'h2;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Bit k may not be cleared while a faster mode stays or k or above is selected
  function [5:0] mode_block;
    input [5:0] clr;
    input [5:0] keep;
    input [5:0] sel;
    integer k;
    begin
      mode_block = 6'h00;
      for (k = 0; k < 6; k = k + 1) begin
        mode_block[k] = clr[k] & (((keep >> (k + 1)) != 6'h00) | ((sel >> k) != 6'h00));
      end
    end
  endfunction

  function [7:0] byte_sum;
    input [7:0] acc;
    input [15:0] word;
    begin
      byte_sum = acc + word[7:0] + word[15:8];
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] state_reg;
  reg [7:0] word_cnt_reg;
  reg [7:0] sum_reg;
  reg [15:0] last_word_reg;
  reg [15:0] words_reg [0:`COS_KEEP_WORDS-1];
  reg modified_reg;
  reg [7:0] feature_reg;
  reg [7:0] sector_count_reg;
  reg [7:0] device_select_reg;
  reg [7:0] error_reg;
  reg [7:0] bad_bit_mask_low_reg;
  reg [7:0] bad_bit_mask_high_reg;
  reg [7:0] bad_word_offset_reg;
  reg [7:0] status_reg;
  reg [7:0] control_reg;
  reg [13:0] mode_sel_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  integer i;

  // ----------------------------------------
  // Bus address phase
  // ----------------------------------------
  wire take = hsel & hready & htrans[1];
  wire wr_take = take & hwrite;
  wire rd_take = take & ~hwrite;
  wire wr_cmd = wr_pend_reg & (wr_addr_reg == `COS_OFS_COMMAND);
  wire wr_data = wr_pend_reg & (wr_addr_reg == `COS_OFS_DATA);

  reg [31:0] rd_next;
  always @* begin
    case (haddr)
      `COS_OFS_COMMAND: rd_next = {24'h000000, status_reg};
      `COS_OFS_FEATURE: rd_next = {24'h000000, feature_reg};
      `COS_OFS_DEV_SELECT: rd_next = {24'h000000, device_select_reg};
      `COS_OFS_ERROR: rd_next = {24'h000000, error_reg};
      `COS_OFS_MASK_LOW: rd_next = {24'h000000, bad_bit_mask_low_reg};
      `COS_OFS_MASK_HIGH: rd_next = {24'h000000, bad_bit_mask_high_reg};
      `COS_OFS_WORD_OFS: rd_next = {24'h000000, bad_word_offset_reg};
      `COS_OFS_STATUS: rd_next = {24'h000000, status_reg};
      `COS_OFS_CONTROL: rd_next = {24'h000000, control_reg};
      `COS_OFS_MODE_SEL: rd_next = {18'h00000, mode_sel_reg};
      `COS_OFS_CUR_DMA: rd_next = {18'h00000, cur_udma, 5'h00, cur_mdma};
      `COS_OFS_CUR_FEAT: rd_next = {23'h000000, cur_feat};
      `COS_OFS_MAX_LOW: rd_next = native_max[31:0];
      `COS_OFS_MAX_HIGH: rd_next = {16'h0000, native_max[47:32]};
      `COS_OFS_SECTOR_COUNT: rd_next = {24'h000000, sector_count_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Command start checks
  // ----------------------------------------
  wire is_set_cmd = (hwdata[7:0] == `COS_OPCODE) & (feature_reg == `COS_SUBFN_SET); // [RL1]
  wire pre_abort = ~control_reg[`COS_CTL_SUPPORTED] | modified_reg
                 | control_reg[`COS_CTL_FREEZE]; // [RL8]

  // ----------------------------------------
  // Overlay evaluation
  // ----------------------------------------
  wire [2:0] w_mdma = words_reg[1][2:0] & FACTORY_MDMA; // [RL6] [RL10]
  wire [5:0] w_udma = words_reg[2][5:0] & FACTORY_UDMA; // [RL6] [RL10]
  wire [8:0] w_feat = words_reg[7][8:0] & FACTORY_FEAT; // [RL7] [RL10]
  wire [63:0] w_lba = {words_reg[6], words_reg[5], words_reg[4], words_reg[3]}; // [RL7]
  wire [2:0] clr_mdma = FACTORY_MDMA & ~w_mdma;
  wire [5:0] clr_udma = FACTORY_UDMA & ~w_udma;
  wire [8:0] clr_feat = FACTORY_FEAT & ~w_feat;
  wire [5:0] mdma_blk6 = mode_block({3'h0, clr_mdma}, {3'h0, w_mdma}, {3'h0, mode_sel_reg[2:0]});
  // Lowest multiword mode is never removable
  wire [2:0] bad_mdma = {mdma_blk6[2:1], clr_mdma[0]};
  wire [5:0] bad_udma = mode_block(clr_udma, w_udma,
                                   mode_sel_reg[`COS_SEL_UDMA_LSB+5:`COS_SEL_UDMA_LSB]);
  reg [8:0] bad_feat;
  always @* begin
    bad_feat = 9'h000;
    bad_feat[`COS_FEAT_HPA] = clr_feat[`COS_FEAT_HPA] & control_reg[`COS_CTL_HPA];
    bad_feat[`COS_FEAT_STANDBY] = clr_feat[`COS_FEAT_STANDBY] & control_reg[`COS_CTL_JUMPER];
    bad_feat[`COS_FEAT_SECURITY] = clr_feat[`COS_FEAT_SECURITY] & control_reg[`COS_CTL_SECURITY_ON];
    bad_feat[`COS_FEAT_SMART] = clr_feat[`COS_FEAT_SMART] & (w_feat[`COS_FEAT_SELFTEST]
                              | w_feat[`COS_FEAT_ERRLOG] | control_reg[`COS_CTL_SMART_ON]);
  end
  wire rev_ok = words_reg[0] == `COS_REVISION; // [RL5]
  wire sig_ok = last_word_reg[7:0] == `COS_SIGNATURE; // [RL2]
  wire sum_ok = sum_reg == 8'h00; // [RL4]
  wire lba_bad = (w_lba == 64'h0) | (w_lba > {16'h0000, FACTORY_MAX_LBA});

  reg ev_abort;
  reg [15:0] ev_mask;
  reg [7:0] ev_ofs;
  always @* begin
    ev_abort = 1'b1;
    ev_mask = 16'h0000;
    ev_ofs = 8'h00;
    if (!rev_ok) begin
      ev_ofs = `COS_OFS_BAD_REV; // [RL17]
    end else if (!sig_ok || !sum_ok) begin
      ev_ofs = `COS_OFS_BAD_SUM; // [RL16]
    end else if (bad_mdma != 3'h0) begin
      ev_mask = {13'h0000, bad_mdma}; // [RL12] [RL13]
      ev_ofs = `COS_WORD_MDMA; // [RL14]
    end else if (bad_udma != 6'h00) begin
      ev_mask = {10'h000, bad_udma}; // [RL12] [RL13]
      ev_ofs = `COS_WORD_UDMA; // [RL14]
    end else if (lba_bad || control_reg[`COS_CTL_HPA]) begin
      // Established protected area forbids any new maximum
      ev_ofs = `COS_OFS_LBA; // [RL15] [RL8]
    end else if (bad_feat != 9'h000) begin
      ev_mask = {7'h00, bad_feat}; // [RL12] [RL13]
      ev_ofs = `COS_WORD_FEAT; // [RL14]
    end else begin
      ev_abort = 1'b0;
    end
  end

  // ----------------------------------------
  // Bus data phase and command engine
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      state_reg <= ST_IDLE;
      word_cnt_reg <= 8'h00;
      sum_reg <= 8'h00;
      last_word_reg <= 16'h0000;
      for (i = 0; i < `COS_KEEP_WORDS; i = i + 1) begin
        words_reg[i] <= 16'h0000;
      end
      modified_reg <= 1'b0;
      feature_reg <= 8'h00;
      sector_count_reg <= 8'h00;
      device_select_reg <= 8'h00;
      error_reg <= 8'h00;
      bad_bit_mask_low_reg <= 8'h00;
      bad_bit_mask_high_reg <= 8'h00;
      bad_word_offset_reg <= 8'h00;
      status_reg <= 8'h00;
      control_reg <= `COS_CTL_RESET;
      mode_sel_reg <= 14'h0000;
      cur_mdma <= FACTORY_MDMA;
      cur_udma <= FACTORY_UDMA;
      cur_feat <= FACTORY_FEAT;
      native_max <= FACTORY_MAX_LBA;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_addr_reg <= haddr;
      end
      if (rd_take) begin
        hrdata <= rd_next;
      end
      status_reg[`COS_ST_DRDY] <= 1'b1;
      // Task-file writes are refused while the command owns them
      if (wr_pend_reg && state_reg == ST_IDLE) begin
        case (wr_addr_reg)
          `COS_OFS_FEATURE: feature_reg <= hwdata[7:0];
          `COS_OFS_DEV_SELECT: device_select_reg <= hwdata[7:0]; // [RL20]
          `COS_OFS_MASK_LOW: bad_bit_mask_low_reg <= hwdata[7:0];
          `COS_OFS_MASK_HIGH: bad_bit_mask_high_reg <= hwdata[7:0];
          `COS_OFS_WORD_OFS: bad_word_offset_reg <= hwdata[7:0];
          `COS_OFS_CONTROL: control_reg <= hwdata[7:0];
          `COS_OFS_MODE_SEL: mode_sel_reg <= hwdata[13:0];
          `COS_OFS_SECTOR_COUNT: sector_count_reg <= hwdata[7:0];
          default: ;
        endcase
      end
      case (state_reg)
        ST_IDLE: begin
          if (wr_cmd && is_set_cmd) begin
            error_reg <= 8'h00;
            bad_bit_mask_low_reg <= 8'h00;
            bad_bit_mask_high_reg <= 8'h00;
            bad_word_offset_reg <= 8'h00;
            word_cnt_reg <= 8'h00;
            sum_reg <= 8'h00;
            if (pre_abort) begin
              error_reg[`COS_ERR_ABRT] <= 1'b1; // [RL8]
              status_reg[`COS_ST_ERR] <= 1'b1; // [RL19]
              status_reg[`COS_ST_DF] <= device_fault; // [RL18]
              status_reg[`COS_ST_DRQ] <= 1'b0;
              status_reg[`COS_ST_BSY] <= 1'b0;
            end else begin
              status_reg[`COS_ST_ERR] <= 1'b0;
              status_reg[`COS_ST_DF] <= 1'b0;
              status_reg[`COS_ST_DRQ] <= 1'b1; // [RL21]
              state_reg <= ST_XFER;
            end
          end else if (wr_cmd) begin
            // Any other opcode, or B1h without subfunction C3h, is aborted with ABRT
            error_reg <= 8'h00;
            error_reg[`COS_ERR_ABRT] <= 1'b1; // [RL8]
            status_reg[`COS_ST_ERR] <= 1'b1; // [RL19]
            status_reg[`COS_ST_DRQ] <= 1'b0;
          end
        end
        ST_XFER: begin
          if (wr_data) begin
            sum_reg <= byte_sum(sum_reg, hwdata[15:0]); // [RL4]
            if (word_cnt_reg < `COS_KEEP_WORDS) begin
              words_reg[word_cnt_reg[2:0]] <= hwdata[15:0];
            end
            word_cnt_reg <= word_cnt_reg + 8'h01;
            if (word_cnt_reg == `COS_LAST_WORD) begin
              last_word_reg <= hwdata[15:0]; // [RL2]
              status_reg[`COS_ST_DRQ] <= 1'b0; // [RL21]
              status_reg[`COS_ST_BSY] <= 1'b1;
              state_reg <= ST_EVAL;
            end
          end
        end
        ST_EVAL: begin
          state_reg <= ST_IDLE;
          status_reg[`COS_ST_BSY] <= 1'b0; // [RL18]
          status_reg[`COS_ST_DRQ] <= 1'b0; // [RL18]
          status_reg[`COS_ST_DF] <= device_fault; // [RL18]
          status_reg[`COS_ST_ERR] <= ev_abort; // [RL19]
          error_reg[`COS_ERR_ABRT] <= ev_abort; // [RL8]
          bad_bit_mask_low_reg <= ev_mask[7:0]; // [RL12]
          bad_bit_mask_high_reg <= ev_mask[15:8]; // [RL13]
          bad_word_offset_reg <= ev_abort ? ev_ofs : 8'h00; // [RL14]
          if (!ev_abort) begin
            modified_reg <= 1'b1;
            cur_mdma <= w_mdma; // [RL9]
            cur_udma <= w_udma; // [RL9]
            cur_feat <= w_feat; // [RL9]
            native_max <= w_lba[47:0]; // [RL11]
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // cos_overlay_set

// file: bench/cos_overlay_set_assertions.sv
// Purpose: port assertions for the overlay set checker
// Assumes: factory mode masks are contiguous from bit 0
// Notes: bound to every instance of the design
`timescale 1ns/1ps
module cos_overlay_set_chk #(
  parameter [47:0] FACTORY_MAX_LBA = 48'h0000_1234_5678
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire device_fault,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire [2:0] cur_mdma,
  input wire [5:0] cur_udma,
  input wire [8:0] cur_feat,
  input wire [47:0] native_max
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_taken = hsel & hready & htrans[1] & !hwrite;
  // ----------------------------------------
  // Bus and capability properties
  // ----------------------------------------
  chk_ready_high: assert property (hreadyout == 1'b1) else $error("wait state inserted");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  chk_rdata_holds: assert property (!$past(rd_taken) |-> $stable(hrdata)) else $error("read data moved");
  chk_mdma_no_gain: assert property ((cur_mdma & ~$past(cur_mdma)) == 3'h0) else $error("mdma bit gained");
  chk_udma_no_gain: assert property ((cur_udma & ~$past(cur_udma)) == 6'h00) else $error("udma bit gained");
  chk_feat_no_gain: assert property ((cur_feat & ~$past(cur_feat)) == 9'h000) else $error("feature gained");
  chk_mdma_base_kept: assert property ($past(cur_mdma[0]) |-> cur_mdma[0]) else $error("mdma 0 dropped");
  chk_udma_contig: assert property (((cur_udma + 6'h01) & cur_udma) == 6'h00) else $error("udma gap");
  chk_max_legal: assert property (native_max != 48'h0 && native_max <= FACTORY_MAX_LBA) else $error("bad max");
  cover property ($fell(cur_mdma[2]));
  cover property ($changed(native_max));
  cover property (rd_taken ##1 hrdata[0]);
endmodule // cos_overlay_set_chk
bind cos_overlay_set cos_overlay_set_chk #(.FACTORY_MAX_LBA(FACTORY_MAX_LBA)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .device_fault(device_fault), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cur_mdma(cur_mdma),
  .cur_udma(cur_udma), .cur_feat(cur_feat), .native_max(native_max));

// file: bench/cos_host_model.sv
// Purpose: host adapter model, AHB-Lite master for the task file
// Assumes: single slave, whole-word transfers only
// Notes: holds the overlay image the bench fills in
`timescale 1ns/1ps
`include "cos_map.vh"
module cos_host_model (
  input wire hclk,
  input wire hready,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  logic [15:0] ov [0:255];
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ----------------------------------------
  // Single transfer, waits on hready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    q = hrdata;
    // Released data lines must not look valid
    hwdata <= ~d;
  endtask
  task automatic send_overlay(input logic bad_sum);
    logic [7:0] s;
    logic [31:0] q;
    s = `COS_SIGNATURE;
    for (int i = 0; i < 255; i++) s = s + ov[i][15:8] + ov[i][7:0];
    ov[255] = {(8'h00 - s) ^ {7'h0, bad_sum}, `COS_SIGNATURE};
    for (int i = 0; i < 256; i++) xfer(1'b1, `COS_OFS_DATA, {16'h0, ov[i]}, q);
  endtask
endmodule // cos_host_model

// file: bench/tb_cos_overlay_set.sv
// Purpose: self-checking bench for the overlay set checker
// Assumes: factory feature word lacks bit 8
// Notes: mode select left at zero before accepting
`timescale 1ns/1ps
`include "cos_map.vh"
module tb_cos_overlay_set;
  logic hclk, hresetn, device_fault, hsel, hwrite;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, cur_mdma;
  logic [31:0] hwdata, hrdata;
  logic hreadyout, hresp;
  logic [5:0] cur_udma;
  logic [8:0] cur_feat;
  logic [47:0] native_max;
  int miscompares = 0;
  int cmp_count = 0;
  cos_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  cos_overlay_set #(.FACTORY_FEAT(9'h0FF)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .device_fault(device_fault), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cur_mdma(cur_mdma),
    .cur_udma(cur_udma), .cur_feat(cur_feat), .native_max(native_max));
  always #5 hclk = ~hclk;
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk({16'h0, q}, {16'h0, e});
  endtask
  task automatic fill(input logic [15:0] rev, w1, w2, input logic [47:0] lba, input logic [15:0] w7);
    for (int i = 0; i < 256; i++) host.ov[i] = 16'h0;
    host.ov[0] = rev;
    host.ov[1] = w1;
    host.ov[2] = w2;
    {host.ov[5], host.ov[4], host.ov[3]} = lba;
    host.ov[7] = w7;
  endtask
  task automatic run_cmd(input logic bad, input logic [7:0] st);
    logic [31:0] q;
    wr(`COS_OFS_FEATURE, 32'hC3);
    wr(`COS_OFS_COMMAND, 32'hB1);
    rd_chk(`COS_OFS_STATUS, 32'h48);
    host.send_overlay(bad);
    // Completion follows a short busy spell
    for (int i = 0; i < 20; i++) begin
      host.xfer(1'b0, `COS_OFS_STATUS, 32'h0, q);
      if (q[7] === 1'b0) break;
    end
    rd_chk(`COS_OFS_STATUS, {24'h0, st});
  endtask
  task automatic abort_case(input logic [7:0] ofs, input logic [7:0] ml, input logic bad);
    run_cmd(bad, 8'h41);
    rd_chk(`COS_OFS_ERROR, 32'h04);
    rd_chk(`COS_OFS_WORD_OFS, {24'h0, ofs});
    rd_chk(`COS_OFS_MASK_LOW, {24'h0, ml});
    rd_chk(`COS_OFS_MASK_HIGH, 32'h00);
    chk({cur_feat, cur_udma, cur_mdma}, {9'h0FF, 6'h3F, 3'h7});
    $display("abort case offset %h done", ofs);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk(`COS_OFS_STATUS, 32'h40);
    rd_chk(`COS_OFS_MAX_LOW, 32'h1234_5678);
    rd_chk(8'h80, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_bad_rev;
    fill(16'h0002, 16'h7, 16'h3F, 48'h1234_5678, 16'h0FF);
    abort_case(8'h00, 8'h00, 1'b0);
  endtask
  task automatic t_bad_sum;
    fill(16'h0001, 16'h7, 16'h3F, 48'h1234_5678, 16'h0FF);
    abort_case(8'hFF, 8'h00, 1'b1);
  endtask
  task automatic t_bad_lba;
    fill(16'h0001, 16'h7, 16'h3F, 48'h0, 16'h0FF);
    abort_case(8'h03, 8'h00, 1'b0);
  endtask
  task automatic t_restrict;
    fill(16'h0001, 16'h6, 16'h3F, 48'h1234_5678, 16'h0FF);
    abort_case(8'h01, 8'h01, 1'b0);
  endtask
  task automatic t_accept;
    wr(`COS_OFS_MODE_SEL, 32'h0);
    wr(`COS_OFS_DEV_SELECT, 32'h10);
    device_fault <= 1'b1;
    fill(16'h0001, 16'h3, 16'h0F, 48'h1000, 16'h1BF);
    run_cmd(1'b0, 8'h60);
    rd_chk(`COS_OFS_ERROR, 32'h00);
    rd_chk(`COS_OFS_MASK_LOW, 32'h00);
    rd_chk(`COS_OFS_DEV_SELECT, 32'h10);
    chk({cur_feat, cur_udma, cur_mdma}, {9'h0BF, 6'h0F, 3'h3});
    chk(native_max, 48'h1000);
    rd_chk(`COS_OFS_MAX_LOW, 32'h1000);
    device_fault <= 1'b0;
    $display("t_accept done");
  endtask
  task automatic t_second;
    wr(`COS_OFS_FEATURE, 32'hC3);
    wr(`COS_OFS_COMMAND, 32'hB1);
    rd_chk(`COS_OFS_STATUS, 32'h41);
    rd_chk(`COS_OFS_ERROR, 32'h04);
    $display("t_second done");
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    device_fault = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_bad_rev;
    t_bad_sum;
    t_bad_lba;
    t_restrict;
    t_accept;
    t_second;
    tally_and_finish;
  end
  // Five overlays of about 800 cycles each fit well inside this span
  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    tally_and_finish;
  end
endmodule // tb_cos_overlay_set
